// ===== design/seg_trig_regs.vh
// register offsets, reset values and limits for the segment trigger tracking block
`ifndef SEG_TRIG_REGS_VH
`define SEG_TRIG_REGS_VH
// printed offsets are not all multiples of four: they are indices, byte address = index * 4
`define PRE_GATE_IDX        20'h0272E
`define POST_GATE_IDX       20'h02774
`define STRETCH_SEL_IDX     20'h3107E
`define TALLY_IDX           20'h310C9
`define CTRL_IDX            20'h31100
`define STATUS_IDX          20'h31101
`define BUDGET_IDX          20'h31102
`define MEM_SHIFT_IDX       20'h31103
`define STRETCH_RST         1'b0
`define CTRL_RST            32'h00000000
`define K_SAMPLES           64'h0000000000000400
`define PRE_GATE_MAX_K      64'h0000000000000010
`define PRE_GATE_MAX_SUB    64'h0000000000000020
`define MEM_BASE_SAMPLES    64'h0000000004000000
`define MEM_SHIFT_MAX       3'h6
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`define RESP_DECERR         2'h3
`endif

// ===== design/segment_trigger_tracking.v
// segment trigger tracking: tally, trigger output, timestamp strobe, gated sampling control
`timescale 1ns/10ps
`include "seg_trig_regs.vh"

module segment_trigger_tracking #(
   parameter TALLY_W = 48,
   parameter ADDR_W  = 22
) (
   input  wire              mclk_i,
   input  wire              rst_b_i,
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output reg               s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output reg               s_axi_wready,
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire              s_axi_arvalid,
   output reg               s_axi_arready,
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   input  wire              trig_event_i,
   input  wire              forced_trig_i,
   input  wire              seg_done_i,
   input  wire              gate_i,
   input  wire              sample_en_i,
   output reg               trig_out_o,
   output reg               ts_strobe_o,
   output reg               store_en_o,
   output reg               acq_running_o
);

   // control word fields
   localparam CTRL_START   = 0;
   localparam CTRL_STOP    = 1;
   localparam CTRL_GATED   = 2;
   localparam CTRL_FIFO    = 3;
   localparam CTRL_TRIGOE  = 4;
   localparam CTRL_TSEN    = 5;

   // gated acquisition states, one-hot
   localparam ST_IDLE  = 4'b0001;
   localparam ST_WAIT  = 4'b0010;
   localparam ST_GATE  = 4'b0100;
   localparam ST_POST  = 4'b1000;

   // trigger, forced and gate pins pass two flip-flops; seg_done_i and sample_en_i are used directly
   reg  [2:0] sy1_q;
   reg  [2:0] sy2_q;
   reg        trig_prev_q;
   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         sy1_q       <= 3'h0;
         sy2_q       <= 3'h0;
         trig_prev_q <= 1'b0;
      end else begin
         sy1_q       <= {gate_i, forced_trig_i, trig_event_i};
         sy2_q       <= sy1_q;
         trig_prev_q <= sy2_q[0];
      end
   end
   wire trig_rise = sy2_q[0] & ~trig_prev_q;
   wire forced    = sy2_q[1];
   wire gate_s    = sy2_q[2];

   // registers
   reg [63:0]        pre_q;
   reg [63:0]        post_q;
   reg               stretch_q;
   reg [5:0]         ctrl_q;
   reg [63:0]        budget_q;
   reg [2:0]         mem_shift_q;
   reg [TALLY_W-1:0] tally_q;
   reg               len_err_q;
   reg [3:0]         st_q;
   reg [63:0]        cnt_q;
   reg [63:0]        stored_q;
   reg [63:0]        pre_have_q;
   reg               seg_open_q;

   // installed capacity in samples, base 64 M doubling up to 4 G
   function [63:0] mem_cap;
      input [2:0] sh;
      begin
         mem_cap = `MEM_BASE_SAMPLES << sh;
      end
   endfunction

   // gated pre-gate limit: capacity-independent 16k - 32 samples, k = 1024
   wire [63:0] pre_limit = `PRE_GATE_MAX_K * `K_SAMPLES - `PRE_GATE_MAX_SUB;

   // write channel: address and data are latched separately, in either order
   reg [ADDR_W-1:0] aw_q;
   reg [31:0]       wd_q;
   reg [3:0]        ws_q;
   reg              aw_ok_q;
   reg              w_ok_q;
   wire [19:0] widx = aw_q[21:2];
   wire        do_wr = aw_ok_q & w_ok_q & ~s_axi_bvalid;
   wire        start_pulse = do_wr & (widx == `CTRL_IDX) & ws_q[0] & wd_q[CTRL_START];
   wire        stop_pulse  = do_wr & (widx == `CTRL_IDX) & ws_q[0] & wd_q[CTRL_STOP];

   // byte-lane merge used for the 64-bit pre, post and budget words
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  be;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1)
            merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   // word index decode of a byte address
   function hit;
      input [ADDR_W-1:0] a;
      input [19:0]       idx;
      begin
         hit = (a[21:2] == idx);
      end
   endfunction

   wire known_w = hit(aw_q, `PRE_GATE_IDX) | hit(aw_q, `PRE_GATE_IDX + 20'h1) |
                  hit(aw_q, `POST_GATE_IDX) | hit(aw_q, `POST_GATE_IDX + 20'h1) |
                  hit(aw_q, `STRETCH_SEL_IDX) | hit(aw_q, `CTRL_IDX) |
                  hit(aw_q, `BUDGET_IDX) | hit(aw_q, `BUDGET_IDX + 20'h1) |
                  hit(aw_q, `MEM_SHIFT_IDX) | hit(aw_q, `STATUS_IDX) |
                  hit(aw_q, `TALLY_IDX) | hit(aw_q, `TALLY_IDX + 20'h1);
   wire [31:0] pre_lo_new = merge(pre_q[31:0], wd_q, ws_q);
   wire [63:0] pre_new    = widx[0] ? {merge(pre_q[63:32], wd_q, ws_q), pre_q[31:0]} : {pre_q[63:32], pre_lo_new};
   // the running/odd-index detail: pre index is even offset 0x272E, so bit0 picks the high word
   wire pre_bad = ctrl_q[CTRL_GATED] & (pre_new > pre_limit);

   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         aw_ok_q       <= 1'b0;
         w_ok_q        <= 1'b0;
         aw_q          <= {ADDR_W{1'b0}};
         wd_q          <= 32'h00000000;
         ws_q          <= 4'h0;
         pre_q         <= 64'h0000000000000000;
         post_q        <= 64'h0000000000000000;
         stretch_q     <= `STRETCH_RST;
         ctrl_q        <= 6'h00;
         budget_q      <= 64'h0000000000000000;
         mem_shift_q   <= 3'h0;
         len_err_q     <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_ok_q & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_ok_q & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_q    <= s_axi_awaddr;
            aw_ok_q <= 1'b1;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wd_q   <= s_axi_wdata;
            ws_q   <= s_axi_wstrb;
            w_ok_q <= 1'b1;
         end
         if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (do_wr) begin
            aw_ok_q      <= 1'b0;
            w_ok_q       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known_w ? `RESP_OKAY : `RESP_DECERR;
            if (hit(aw_q, `PRE_GATE_IDX) | hit(aw_q, `PRE_GATE_IDX + 20'h1)) begin
               if (pre_bad) begin // rejected, old value kept
                  len_err_q   <= 1'b1;
                  s_axi_bresp <= `RESP_SLVERR;
               end else begin
                  pre_q <= pre_new;
               end
            end
            if (hit(aw_q, `POST_GATE_IDX))
               post_q[31:0] <= merge(post_q[31:0], wd_q, ws_q);
            if (hit(aw_q, `POST_GATE_IDX + 20'h1))
               post_q[63:32] <= merge(post_q[63:32], wd_q, ws_q);
            if (hit(aw_q, `STRETCH_SEL_IDX) & ws_q[0])
               stretch_q <= wd_q[0];
            if (hit(aw_q, `CTRL_IDX) & ws_q[0])
               ctrl_q <= {wd_q[5:2], 2'b00}; // start and stop self-clear
            if (hit(aw_q, `BUDGET_IDX))
               budget_q[31:0] <= merge(budget_q[31:0], wd_q, ws_q);
            if (hit(aw_q, `BUDGET_IDX + 20'h1))
               budget_q[63:32] <= merge(budget_q[63:32], wd_q, ws_q);
            if (hit(aw_q, `MEM_SHIFT_IDX) & ws_q[0])
               mem_shift_q <= (wd_q[2:0] > `MEM_SHIFT_MAX) ? `MEM_SHIFT_MAX : wd_q[2:0];
            if (hit(aw_q, `STATUS_IDX) & ws_q[0] & wd_q[1])
               len_err_q <= 1'b0; // write one to clear
         end
      end
   end

   // effective budget never exceeds installed capacity
   wire [63:0] cap        = mem_cap(mem_shift_q);
   wire [63:0] eff_budget = (budget_q > cap) ? cap : budget_q;
   wire        fifo_mode  = ctrl_q[CTRL_FIFO];
   wire        budget_hit = ~fifo_mode & (stored_q + 64'h1 >= eff_budget);
   wire        take       = sample_en_i & store_en_o;

   // acquisition state, tally, trigger output and gated storage
   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         acq_running_o <= 1'b0;
         tally_q       <= {TALLY_W{1'b0}};
         trig_out_o    <= 1'b0;
         ts_strobe_o   <= 1'b0;
         seg_open_q    <= 1'b0;
         st_q          <= ST_IDLE;
         cnt_q         <= 64'h0000000000000000;
         stored_q      <= 64'h0000000000000000;
         pre_have_q    <= 64'h0000000000000000;
         store_en_o    <= 1'b0;
      end else begin
         ts_strobe_o <= 1'b0;
         if (start_pulse) begin
            acq_running_o <= 1'b1;
            tally_q       <= {TALLY_W{1'b0}};
            stored_q      <= 64'h0000000000000000;
            pre_have_q    <= 64'h0000000000000000;
            trig_out_o    <= 1'b0;
            seg_open_q    <= 1'b0;
            // the gated bit of the same write decides, ctrl_q still holds the old word here
            st_q          <= wd_q[CTRL_GATED] ? ST_WAIT : ST_IDLE;
            store_en_o    <= 1'b0;
         end else if (acq_running_o) begin
            // forced triggers open segments but are not counted, so the host can tell them apart
            if (trig_rise & ~forced) begin
               tally_q <= tally_q + {{(TALLY_W-1){1'b0}}, 1'b1}; // wraps
               // strobe marks the trigger instant; pre-trigger samples lie before it
               ts_strobe_o <= ctrl_q[CTRL_TSEN];
            end
            if (trig_rise) begin
               seg_open_q <= 1'b1;
               if (ctrl_q[CTRL_TRIGOE])
                  trig_out_o <= 1'b1;
            end
            if (seg_done_i & seg_open_q) begin
               seg_open_q <= 1'b0;
               if (~stretch_q)
                  trig_out_o <= 1'b0;
            end
            if (take)
               stored_q <= stored_q + 64'h1;
            if (sample_en_i & ~store_en_o & (pre_have_q < pre_q))
               pre_have_q <= pre_have_q + 64'h1; // history window filling
            case (st_q)
               ST_IDLE: begin
                  store_en_o <= 1'b0;
               end
               ST_WAIT: begin
                  // pre-gate samples come from the history window already filled
                  if (gate_s) begin
                     st_q       <= ST_GATE;
                     store_en_o <= 1'b1;
                     stored_q   <= stored_q + pre_have_q;
                  end
               end
               ST_GATE: begin
                  if (~gate_s) begin
                     st_q  <= ST_POST;
                     cnt_q <= post_q;
                     store_en_o <= (post_q != 64'h0);
                     if (post_q == 64'h0)
                        st_q <= ST_WAIT;
                  end
               end
               ST_POST: begin
                  if (gate_s) begin
                     st_q <= ST_GATE;
                  end else if (sample_en_i) begin
                     cnt_q <= cnt_q - 64'h1;
                     if (cnt_q == 64'h1) begin
                        st_q       <= ST_WAIT; // pause until next gate
                        store_en_o <= 1'b0;
                        pre_have_q <= 64'h0000000000000000;
                     end
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
            // budget exhaustion ends the run at once, even mid-gate
            if (stop_pulse | (take & budget_hit)) begin
               acq_running_o <= 1'b0;
               store_en_o    <= 1'b0;
               trig_out_o    <= 1'b0;
               ts_strobe_o   <= 1'b0; // no strobe outside a running acquisition
               st_q          <= ST_IDLE;
            end
         end
      end
   end

   // read channel: one-cycle answer after address accept
   wire [19:0] ridx = s_axi_araddr[21:2];
   reg  [31:0] rd_d;
   reg  [1:0]  rr_d;
   always @* begin
      rd_d = 32'h00000000;
      rr_d = `RESP_OKAY;
      case (ridx)
         `PRE_GATE_IDX:          rd_d = pre_q[31:0];
         `PRE_GATE_IDX + 20'h1:  rd_d = pre_q[63:32];
         `POST_GATE_IDX:         rd_d = post_q[31:0];
         `POST_GATE_IDX + 20'h1: rd_d = post_q[63:32];
         `STRETCH_SEL_IDX:       rd_d = {31'h0, stretch_q};
         `TALLY_IDX:             rd_d = tally_q[31:0];
         `TALLY_IDX + 20'h1:     rd_d = {16'h0000, tally_q[47:32]};
         `CTRL_IDX:              rd_d = {26'h0, ctrl_q};
         `STATUS_IDX:            rd_d = {24'h0, st_q, trig_out_o, 1'b0, len_err_q, acq_running_o};
         `BUDGET_IDX:            rd_d = budget_q[31:0];
         `BUDGET_IDX + 20'h1:    rd_d = budget_q[63:32];
         `MEM_SHIFT_IDX:         rd_d = {29'h0, mem_shift_q};
         default:                rr_d = `RESP_DECERR;
      endcase
   end

   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_d;
            s_axi_rresp  <= rr_d;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // segment_trigger_tracking

// ===== testbench/seg_trig_sva.sv
// assertion checker for the segment trigger tracking block
`timescale 1ns/10ps
module seg_trig_sva #(
   parameter TALLY_W = 48,
   parameter ADDR_W  = 22
) (
   input wire mclk_i,
   input wire rst_b_i,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire trig_event_i,
   input wire seg_done_i,
   input wire trig_out_o,
   input wire ts_strobe_o,
   input wire store_en_o,
   input wire acq_running_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   // handshakes, and the pin history a rising output needs (sync delay of two plus a register)
   sequence s_ar_taken; s_axi_arvalid && s_axi_arready; endsequence
   sequence s_aw_taken; s_axi_awvalid && s_axi_awready; endsequence
   sequence s_trig_seen;
      $past(trig_event_i, 2) || $past(trig_event_i, 3) || $past(trig_event_i, 4) || $past(trig_event_i, 5);
   endsequence
   chk_reset_quiet: assert property ($rose(rst_b_i) |-> !(trig_out_o || ts_strobe_o || store_en_o || acq_running_o))
      else $error("output active right after reset");
   chk_ts_single: assert property (ts_strobe_o |=> !ts_strobe_o)
      else $error("timestamp strobe wider than one cycle");
   chk_ts_in_acq: assert property (ts_strobe_o |-> acq_running_o)
      else $error("timestamp strobe outside acquisition");
   chk_out_cause: assert property ($rose(trig_out_o) |-> s_trig_seen)
      else $error("trigger output rose without a trigger");
   chk_out_fall: assert property ($fell(trig_out_o) |-> $past(seg_done_i) || $past(seg_done_i, 2) || !acq_running_o)
      else $error("trigger output fell before segment end");
   chk_out_stop: assert property (trig_out_o && !acq_running_o |=> !trig_out_o)
      else $error("trigger output held after acquisition end");
   chk_store_idle: assert property (!acq_running_o [*2] |-> !store_en_o)
      else $error("storing while acquisition stopped");
   chk_r_answer: assert property (s_ar_taken |=> s_axi_rvalid)
      else $error("read data late");
   chk_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answered twice");
   chk_b_answer: assert property (s_aw_taken |-> ##[1:6] s_axi_bvalid)
      else $error("write response missing");
   chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answered twice");
endmodule // seg_trig_sva

bind segment_trigger_tracking seg_trig_sva #(.TALLY_W(TALLY_W), .ADDR_W(ADDR_W)) u_sva (
   .mclk_i(mclk_i), .rst_b_i(rst_b_i), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .trig_event_i(trig_event_i), .seg_done_i(seg_done_i), .trig_out_o(trig_out_o),
   .ts_strobe_o(ts_strobe_o), .store_en_o(store_en_o), .acq_running_o(acq_running_o));

// ===== testbench/trig_gate_src.sv
// trigger and gate source model for the front-end side
`timescale 1ns/10ps
module trig_gate_src (
   input  wire  mclk_i,
   output logic trig_event_i,
   output logic forced_trig_i,
   output logic seg_done_i,
   output logic gate_i,
   output logic sample_en_i
);
   initial begin
      trig_event_i = 1'b0;
      forced_trig_i = 1'b0;
      seg_done_i = 1'b0;
      gate_i = 1'b0;
      sample_en_i = 1'b0;
   end
   // half-rate sample strobe so post counts span twice as many cycles
   always @(posedge mclk_i) sample_en_i <= !sample_en_i;
   // trigger edge, marked as a forced trigger when the argument is set; forced flag set a cycle ahead
   task automatic fire(input logic forced);
      @(posedge mclk_i);
      forced_trig_i <= forced;
      @(posedge mclk_i);
      trig_event_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      trig_event_i <= 1'b0;
      forced_trig_i <= 1'b0;
      repeat (8) @(posedge mclk_i);
      seg_done_i <= 1'b1;
      @(posedge mclk_i);
      seg_done_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
   endtask
   task automatic set_gate(input logic v);
      @(posedge mclk_i);
      gate_i <= v;
   endtask
endmodule // trig_gate_src

// ===== testbench/segment_trigger_tracking_tb.sv
// self-checking bench for the segment trigger tracking block
`timescale 1ns/10ps
`include "seg_trig_regs.vh"
module segment_trigger_tracking_tb;
   localparam [21:0] A_PRE = {`PRE_GATE_IDX, 2'b00};
   localparam [21:0] A_POST = {`POST_GATE_IDX, 2'b00};
   localparam [21:0] A_STR = {`STRETCH_SEL_IDX, 2'b00};
   localparam [21:0] A_TAL = {`TALLY_IDX, 2'b00};
   localparam [21:0] A_CTL = {`CTRL_IDX, 2'b00};
   localparam [21:0] A_STA = {`STATUS_IDX, 2'b00};
   localparam [21:0] A_BUD = {`BUDGET_IDX, 2'b00};
   localparam int    LIMIT = 10000;
   logic        mclk_i, rst_b_i, awv, wv, bry, arv, rry, out_q;
   logic [21:0] awa, ara;
   logic [31:0] wd, rnd, pre;
   logic [3:0]  ws, wsel;
   logic [65:0] e_r;
   logic [65:0] rq[$];
   logic [1:0]  wq[$];
   wire         awr, wr_r, bv, arr, rv, trig, frc, done, gate, smp, tout, ts, store, run;
   wire  [1:0]  br, rr;
   wire  [31:0] rdat;
   int          fails, n_checks, n_ts, n_rise, cyc, n;
   segment_trigger_tracking #(.TALLY_W(48), .ADDR_W(22)) dut (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .trig_event_i(trig),
      .forced_trig_i(frc), .seg_done_i(done), .gate_i(gate), .sample_en_i(smp), .trig_out_o(tout),
      .ts_strobe_o(ts), .store_en_o(store), .acq_running_o(run));
   trig_gate_src src (.mclk_i(mclk_i), .trig_event_i(trig), .forced_trig_i(frc), .seg_done_i(done),
      .gate_i(gate), .sample_en_i(smp));
   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict;
      if (fails == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // write: address and data offered together, each dropped when taken, bready held until bvalid
   task automatic wr(input logic [21:0] a, input logic [31:0] d, input logic [1:0] er);
      wq.push_back(er);
      @(posedge mclk_i);
      awa <= a;
      wd <= d;
      ws <= wsel;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (awr) awv <= 1'b0;
         if (wr_r) wv <= 1'b0;
      end while (!bv);
      bry <= 1'b0;
   endtask
   // read: the mask drops bits whose value the rules leave open
   task automatic rd(input logic [21:0] a, input logic [31:0] m, input logic [31:0] d, input logic [1:0] er);
      rq.push_back({m, d, er});
      @(posedge mclk_i);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (arr) arv <= 1'b0;
      end while (!rv);
      rry <= 1'b0;
   endtask
   // response watcher takes the oldest note at each answer; also counts strobes and cuts hangs short
   always @(posedge mclk_i) begin
      if (bv && bry) chk("bresp", br, wq.pop_front());
      if (rv && rry) begin
         e_r = rq.pop_front();
         chk("rdata", rdat & e_r[65:34], e_r[33:2]);
         chk("rresp", rr, e_r[1:0]);
      end
      out_q <= tout;
      if (ts) n_ts++;
      if (tout && !out_q) n_rise++;
      cyc++;
      if (cyc == LIMIT) begin
         fails++;
         give_verdict;
      end
   end
   initial begin
      {rst_b_i, awv, wv, bry, arv, rry} = 6'h00;
      awa = 22'h0;
      ara = 22'h0;
      wd = 32'h0;
      ws = 4'hF;
      wsel = 4'hF;
      rnd = 32'h48FD;
      repeat (2) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      rd(A_STR, '1, 32'h0, `RESP_OKAY);
      rd(22'h10, '1, 32'h0, `RESP_DECERR);
      wr(22'h10, 32'h1, `RESP_DECERR);
      // byte lane 0 masked off: the stretch bit must keep its old value
      wsel = 4'hE;
      wr(A_STR, 32'h1, `RESP_OKAY);
      wsel = 4'hF;
      rd(A_STR, '1, 32'h0, `RESP_OKAY);
      // both stretch settings in memory and streaming acquisition
      for (int md = 0; md < 4; md++) begin
         wr(A_STR, {31'h0, md[0]}, `RESP_OKAY);
         wr(A_CTL, {26'h0, 2'b11, md[1], 3'b001}, `RESP_OKAY);
         rd(A_TAL, '1, 32'h0, `RESP_OKAY);
         rnd = lfsr(rnd);
         n = 2 + rnd[1:0];
         n_ts = 0;
         n_rise = 0;
         for (int i = 0; i < n; i++) src.fire(1'b0);
         rd(A_TAL, '1, n, `RESP_OKAY);
         rd(A_TAL + 22'h4, '1, 32'h0, `RESP_OKAY);
         chk("ts_count", n_ts, n);
         chk("out_rises", n_rise, md[0] ? 1 : n);
         chk("out_level", tout, md[0]);
         src.fire(1'b1);
         rd(A_TAL, '1, n, `RESP_OKAY);
         wr(A_CTL, 32'h2, `RESP_OKAY);
         repeat (4) @(posedge mclk_i);
         chk("stopped", {run, tout}, 2'b00);
      end
      // gated pre-gate limit: oversize refused and old value kept, boundary and random accepted
      wr(A_CTL, 32'h4, `RESP_OKAY);
      wr(A_PRE, 32'h4, `RESP_OKAY);
      wr(A_PRE, 32'h3FE1, `RESP_SLVERR);
      rd(A_PRE, '1, 32'h4, `RESP_OKAY);
      rd(A_STA, 32'h2, 32'h2, `RESP_OKAY);
      wr(A_PRE, 32'h3FE0, `RESP_OKAY);
      rnd = lfsr(rnd);
      pre = rnd % 32'h3FE1;
      wr(A_PRE, pre, `RESP_OKAY);
      rd(A_PRE, '1, pre, `RESP_OKAY);
      // gated run with a small budget: store in gate, after it, pause, then stop mid-gate
      wr(A_PRE, 32'h4, `RESP_OKAY);
      wr(A_POST, 32'h8, `RESP_OKAY);
      wr(A_BUD, 32'hC8, `RESP_OKAY);
      wr(A_BUD + 22'h4, 32'h0, `RESP_OKAY);
      wr(A_CTL, 32'h5, `RESP_OKAY);
      src.set_gate(1'b1);
      repeat (8) @(posedge mclk_i);
      chk("store_gate", store, 1'b1);
      src.set_gate(1'b0);
      repeat (6) @(posedge mclk_i);
      chk("store_post", store, 1'b1);
      repeat (40) @(posedge mclk_i);
      chk("store_pause", {run, store}, 2'b10);
      src.set_gate(1'b1);
      repeat (600) @(posedge mclk_i);
      chk("budget_stop", {run, store}, 2'b00);
      // second reset after the budget stop: stretch setting back to its default, outputs quiet
      @(posedge mclk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      rd(A_STR, '1, 32'h0, `RESP_OKAY);
      chk("reset_out", {run, store, tout, ts}, 4'h0);
      give_verdict;
   end
endmodule // segment_trigger_tracking_tb
